// ### rtl/ftc_pkg.sv
package ftc_pkg;

  // Command codes
  localparam logic [15:0] CMD_FAN_CLEAN = 16'h5607;
  localparam logic [15:0] CMD_TEMP_OFS = 16'h60B2;

  // Timing in printed units, and clock rate
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned FAN_CLEAN_S = 10;
  localparam int unsigned POST_PROC_MS = 20;
  localparam int unsigned INTERVAL_S = 1;
  localparam int unsigned FAN_CLEAN_CYC = FAN_CLEAN_S * CLK_HZ;
  localparam int unsigned POST_PROC_CYC = POST_PROC_MS * (CLK_HZ / 1000);
  localparam int unsigned INTERVAL_CYC = INTERVAL_S * CLK_HZ;

  // Payload layout
  localparam int NUM_SLOTS = 5;
  localparam int PAY_BYTES = 12;
  localparam int BYTES_PER_WORD = 3;
  localparam logic [15:0] SLOT_MAX = 16'h0004;
  localparam int SLOPE_SCALE = 10000;
  localparam int FRAC_BITS = 16;

  // Check byte: CRC-8, polynomial and initial value
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COMP = 8'h0C;

  // Status bit positions
  localparam int ST_ERR_BUSY = 0;
  localparam int ST_ERR_CMD = 1;
  localparam int ST_ERR_MODE = 2;
  localparam int ST_ERR_LEN = 3;
  localparam int ST_ERR_CRC = 4;
  localparam int ST_ERR_SLOT = 5;
  localparam int ST_BUSY = 8;
  localparam int ST_FAN = 9;
  localparam int ST_CNT_LSB = 12;

  // Register bus request group
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ftc_bus_t;

  // Whole block state
  typedef struct packed {
    logic [PAY_BYTES-1:0][7:0] pay;
    logic [3:0] cnt;
    logic fan_on;
    logic [31:0] fan_cnt;
    logic busy;
    logic [31:0] pp_cnt;
    logic [31:0] tick_cnt;
    logic [NUM_SLOTS-1:0][15:0] tgt_off;
    logic [NUM_SLOTS-1:0][15:0] tgt_slope;
    logic [NUM_SLOTS-1:0][15:0] tcon;
    logic [NUM_SLOTS-1:0][31:0] app_off;
    logic [NUM_SLOTS-1:0][31:0] app_slope;
    logic [15:0] comp;
    logic [5:0] err;
    logic [31:0] rd_data;
  } ftc_state_t;

  // CRC-8 over one 16-bit word, high byte first
  function automatic logic [7:0] ftc_crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int b = 15; b >= 0; b--) begin
      if (c[7] ^ w[b]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // One smoothing step of a 16.16 value toward its target
  function automatic logic [31:0] ftc_smooth(input logic [15:0] tgt,
                                             input logic [31:0] app,
                                             input logic [15:0] tc);
    logic signed [33:0] diff;
    logic signed [33:0] step;
    diff = $signed({{2{tgt[15]}}, tgt, 16'h0000}) - $signed({{2{app[31]}}, app});
    if (tc == 16'h0000) begin
      step = diff;
    end else begin
      step = diff / $signed({18'h00000, tc});
    end
    return app + step[31:0];
  endfunction

endpackage

// ### rtl/ftc_core.sv
module ftc_core import ftc_pkg::*; #(
  parameter int unsigned FAN_CYC = FAN_CLEAN_CYC,
  parameter int unsigned PP_CYC = POST_PROC_CYC,
  parameter int unsigned TICK_CYC = INTERVAL_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic measuring,
  input wire logic [15:0] raw_temp,
  output logic fan_max,
  output logic busy,
  output logic [15:0] comp_temp
);

  ftc_state_t st_r;
  ftc_state_t st_nxt;
  ftc_bus_t bus;
  logic [NUM_SLOTS-1:0][31:0] sm_off;
  logic [NUM_SLOTS-1:0][31:0] sm_slope;
  logic [3:0][15:0] word;
  logic [3:0] crc_ok;

  // Bundle the bus request
  assign bus.wr = bus_wr;
  assign bus.rd = bus_rd;
  assign bus.addr = bus_addr;
  assign bus.wdata = bus_wdata;

  // Split payload into words and check each word's check byte
  generate
    for (genvar k = 0; k < 4; k++) begin : g_word
      assign word[k] = {st_r.pay[BYTES_PER_WORD*k], st_r.pay[BYTES_PER_WORD*k+1]};
      assign crc_ok[k] = (ftc_crc8(word[k]) == st_r.pay[BYTES_PER_WORD*k+2]);
    end
  endgenerate

  // Per-slot smoothing step taken on each interval tick
  generate
    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
      assign sm_off[i] = ftc_smooth(st_r.tgt_off[i], st_r.app_off[i], st_r.tcon[i]);
      assign sm_slope[i] = ftc_smooth(st_r.tgt_slope[i], st_r.app_slope[i],
                                      st_r.tcon[i]);
    end
  endgenerate

  // Next-state logic
  always_comb begin
    logic signed [51:0] slope_sum;
    logic signed [51:0] off_sum;
    logic signed [51:0] prod;
    logic signed [51:0] total;
    logic [15:0] code;
    logic [15:0] slot;
    slope_sum = '0;
    off_sum = '0;
    prod = '0;
    total = '0;
    code = bus.wdata[15:0];
    slot = word[3];
    st_nxt = st_r;
    st_nxt.rd_data = 32'h00000000;

    // Fan cleaning timer stops the fan by itself
    if (st_r.fan_on) begin
      if (st_r.fan_cnt == 32'h00000000) begin
        st_nxt.fan_on = 1'b0;
      end else begin
        st_nxt.fan_cnt = st_r.fan_cnt - 32'h00000001;
      end
    end

    // Post-processing window after an accepted command
    if (st_r.busy) begin
      if (st_r.pp_cnt == 32'h00000000) begin
        st_nxt.busy = 1'b0;
      end else begin
        st_nxt.pp_cnt = st_r.pp_cnt - 32'h00000001;
      end
    end

    // One-second interval paces smoothing
    if (st_r.tick_cnt == 32'(TICK_CYC - 1)) begin
      st_nxt.tick_cnt = 32'h00000000;
      st_nxt.app_off = sm_off;
      st_nxt.app_slope = sm_slope;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h00000001;
    end

    // Payload byte push
    if (bus.wr && bus.addr == ADDR_DATA) begin
      if (st_r.cnt < 4'(PAY_BYTES)) begin
        st_nxt.pay[st_r.cnt] = bus.wdata[7:0];
        st_nxt.cnt = st_r.cnt + 4'h1;
      end else begin
        st_nxt.err[ST_ERR_LEN] = 1'b1;
      end
    end else if (bus.wr && bus.addr == ADDR_CMD) begin
      // Command execution; errors describe the latest command and any later payload push past the last byte
      st_nxt.err = 6'h00;
      st_nxt.cnt = 4'h0;
      if (st_r.busy) begin
        st_nxt.err[ST_ERR_BUSY] = 1'b1;
      end else if (code == CMD_FAN_CLEAN) begin
        if (measuring) begin
          st_nxt.err[ST_ERR_MODE] = 1'b1;
        end else begin
          st_nxt.fan_on = 1'b1;
          st_nxt.fan_cnt = 32'(FAN_CYC - 1);
          st_nxt.busy = 1'b1;
          st_nxt.pp_cnt = 32'(PP_CYC - 1);
        end
      end else if (code == CMD_TEMP_OFS) begin
        // Accepted in either mode
        st_nxt.busy = 1'b1;
        st_nxt.pp_cnt = 32'(PP_CYC - 1);
        if (st_r.cnt != 4'(PAY_BYTES)) begin
          st_nxt.err[ST_ERR_LEN] = 1'b1;
        end else if (!(&crc_ok)) begin
          st_nxt.err[ST_ERR_CRC] = 1'b1;
        end else if (slot > SLOT_MAX) begin
          st_nxt.err[ST_ERR_SLOT] = 1'b1;
        end else begin
          st_nxt.tgt_off[slot[2:0]] = word[0];
          st_nxt.tgt_slope[slot[2:0]] = word[1];
          st_nxt.tcon[slot[2:0]] = word[2];
        end
      end else begin
        st_nxt.err[ST_ERR_CMD] = 1'b1;
      end
    end

    // Register read, data valid the following cycle only
    if (bus.rd) begin
      if (bus.addr == ADDR_STATUS) begin
        st_nxt.rd_data[5:0] = st_r.err;
        st_nxt.rd_data[ST_BUSY] = st_r.busy;
        st_nxt.rd_data[ST_FAN] = st_r.fan_on;
        st_nxt.rd_data[ST_CNT_LSB+3:ST_CNT_LSB] = st_r.cnt;
      end else if (bus.addr == ADDR_COMP) begin
        st_nxt.rd_data = {{16{st_r.comp[15]}}, st_r.comp};
      end else begin
        st_nxt.rd_data = 32'h00000000;
      end
    end

    // Sum all slot contributions
    for (int i = 0; i < NUM_SLOTS; i++) begin
      slope_sum = slope_sum + 52'($signed(st_r.app_slope[i]));
      off_sum = off_sum + 52'($signed(st_r.app_off[i][31:FRAC_BITS]));
    end

    // Raw plus slope times raw plus offset, all in 1/200 degree
    prod = 52'($signed(raw_temp)) * slope_sum;
    total = 52'($signed(raw_temp)) + ((prod >>> FRAC_BITS) / 52'(SLOPE_SCALE))
            + off_sum;
    st_nxt.comp = total[15:0];
  end

  // State register; reset zeroes every slot
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign bus_rdata = st_r.rd_data;
  assign fan_max = st_r.fan_on;
  assign busy = st_r.busy;
  assign comp_temp = st_r.comp;

endmodule // ftc_core

// ### tb/ftc_properties.sv
module ftc_properties import ftc_pkg::*; #(
  parameter int unsigned FAN_CYC = 50
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic measuring,
  input wire logic fan_max,
  input wire logic busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic cmd_w;
  logic fan_w;
  logic [31:0] run_r;
  // Command writes that the block must take
  assign cmd_w = bus_wr && bus_addr == ADDR_CMD && !busy;
  assign fan_w = cmd_w && bus_wdata[15:0] == CMD_FAN_CLEAN;
  // Length of the current full-speed run
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_r <= '0;
    end else begin
      run_r <= fan_max ? run_r + 32'h1 : '0;
    end
  end
  fan_start_a: assert property (fan_w && !measuring |=> fan_max)
    else $error("fan not started");
  fan_mode_a: assert property (fan_w && measuring && !fan_max |=> !fan_max && !busy)
    else $error("fan started while measuring");
  ofs_mode_a: assert property (cmd_w && bus_wdata[15:0] == CMD_TEMP_OFS |=> busy)
    else $error("offset command not taken");
  fan_len_a: assert property ($fell(fan_max) |-> run_r == FAN_CYC)
    else $error("fan run length wrong");
  fan_cap_a: assert property (run_r <= FAN_CYC)
    else $error("fan run too long");
  busy_end_a: assert property ($rose(busy) |-> busy [*8] ##[1:12] !busy)
    else $error("post processing time wrong");
  busy_hold_a: assert property (bus_wr && bus_addr == ADDR_CMD && busy && !fan_max |=> !fan_max)
    else $error("command taken while busy");
  rd_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == '0)
    else $error("read data outside slot");
endmodule // ftc_properties

bind ftc_core ftc_properties #(.FAN_CYC(FAN_CYC)) u_ftc_properties (.sys_clk, .rst,
  .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .measuring, .fan_max, .busy);

// ### tb/ftc_hm.sv
module ftc_hm import ftc_pkg::*; (
  input wire logic sys_clk,
  output ftc_bus_t bus,
  input wire logic [31:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus = '0;
  // Check byte over one word, high byte first
  function automatic logic [7:0] crc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int b = 15; b >= 0; b--) begin
      c = (c[7] ^ w[b]) ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  // One strobe cycle, released at the following edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge sys_clk);
    bus <= '0;
    #1 d = bus_rdata;
  endtask
  // Offset, slope, constant, slot; bad spoils every check byte
  task automatic ofs(input logic [3:0][15:0] w, input logic bad);
    for (int i = 3; i >= 0; i--) begin
      wr(ADDR_DATA, {24'h000000, w[i][15:8]});
      wr(ADDR_DATA, {24'h000000, w[i][7:0]});
      wr(ADDR_DATA, {24'h000000, crc(w[i]) ^ {7'h00, bad}});
    end
    wr(ADDR_CMD, {16'h0000, CMD_TEMP_OFS});
  endtask
endmodule // ftc_hm

// ### tb/test_fan_clean_temp_offset_cmds.sv
module test_fan_clean_temp_offset_cmds import ftc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic measuring = 1'b0;
  logic [15:0] raw_temp = 16'h0000;
  logic [15:0] z = 16'h0000;
  logic [31:0] seed = 32'h0001_4915;
  logic [31:0] bus_rdata, d;
  logic [15:0] comp_temp, o1, o2, os;
  logic fan_max, busy;
  ftc_bus_t hb;
  int bad_count = 0;
  int num_checks = 0;
  int n;
  ftc_core #(.FAN_CYC(50), .PP_CYC(10), .TICK_CYC(20)) u_ftc_core (.sys_clk, .rst,
    .bus_addr(hb.addr), .bus_wdata(hb.wdata), .bus_wr(hb.wr), .bus_rd(hb.rd), .bus_rdata,
    .measuring, .raw_temp, .fan_max, .busy, .comp_temp);
  ftc_hm u_ftc_hm (.sys_clk, .bus(hb), .bus_rdata);
  initial forever #12.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Raw plus slope term plus summed offsets
  function automatic logic [15:0] ex(input logic [15:0] s, input logic [15:0] o);
    int p;
    p = $signed(raw_temp) * $signed(s);
    p = p / 10000;
    return raw_temp + p[15:0] + o;
  endfunction
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic drv(input logic m, input logic [15:0] r);
    @(posedge sys_clk);
    measuring <= m;
    raw_temp <= r;
  endtask
  // Bounded wait for the compensated value
  task automatic wait_comp(input logic [15:0] e);
    for (int k = 0; k < 40 && comp_temp !== e; k++) begin
      tick(1);
    end
    chk(comp_temp === e, "comp value");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      drv(1'b0, d[15:0]);
      tick(1);
      chk(comp_temp === raw_temp, "default comp");
    end
    u_ftc_hm.wr(ADDR_CMD, {16'h0000, CMD_FAN_CLEAN});
    tick(0);
    n = int'(fan_max);
    for (int i = 0; i < 80; i++) begin
      tick(1);
      n += int'(fan_max);
    end
    chk(n == 50, "fan run length");
    $display("fan test done");
    drv(1'b1, raw_temp);
    u_ftc_hm.wr(ADDR_CMD, {16'h0000, CMD_FAN_CLEAN});
    u_ftc_hm.rd(ADDR_STATUS, d);
    chk(d[ST_ERR_MODE] === 1'b1 && fan_max === 1'b0, "fan while measuring");
    u_ftc_hm.rd(8'h10, d);
    chk(d === 32'h0000_0000, "unmapped read");
    $display("mode test done");
    d = rnd();
    o1 = {{7{d[8]}}, d[8:0]};
    o2 = {{7{d[24]}}, d[24:16]};
    os = o1 + o2;
    u_ftc_hm.ofs({o1, z, z, z}, 1'b0);
    wait_comp(ex(z, o1));
    u_ftc_hm.ofs({o2, z, z, 16'h0004}, 1'b0);
    wait_comp(ex(z, os));
    u_ftc_hm.ofs({o2, z, z, 16'h0005}, 1'b0);
    u_ftc_hm.ofs({o1, z, z, 16'h0001}, 1'b1);
    u_ftc_hm.wr(ADDR_CMD, {16'h0000, CMD_FAN_CLEAN});
    tick(50);
    chk(comp_temp === ex(z, os), "discarded");
    drv(1'b1, 16'h1388);
    u_ftc_hm.ofs({z, 16'h07D0, z, 16'h0002}, 1'b0);
    wait_comp(ex(16'h07D0, os));
    u_ftc_hm.rd(ADDR_COMP, d);
    chk(d[15:0] === ex(16'h07D0, os), "comp read");
    u_ftc_hm.ofs({16'h0190, z, 16'h0002, 16'h0001}, 1'b0);
    wait_comp(ex(16'h07D0, os + 16'h00C8));
    wait_comp(ex(16'h07D0, os + 16'h012C));
    $display("offset test done");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    tick(2);
    chk(comp_temp === raw_temp, "slots cleared");
    $display("reset test done");
    end_of_test();
  end
endmodule // test_fan_clean_temp_offset_cmds
